//--- src/sdc_pkg.sv
// Shared constants of the card register bank and of its controller.
// Assumes both ends run on one clock and use the link in sdc_link_if.
package sdc_pkg;
  localparam int WORD_W = 32;
  localparam logic [1:0] SEL_CSD = 2'h0;
  localparam logic [1:0] SEL_RCA = 2'h1;
  localparam logic [1:0] SEL_CFG = 2'h2;
  localparam logic [1:0] CSD_WORDS_LAST = 2'h3;
  localparam logic [1:0] RCA_WORDS_LAST = 2'h0;
  localparam logic [1:0] CFG_WORDS_LAST = 2'h1;
  localparam logic [7:0] ACCESS_TIME = 8'h2D;
  localparam logic [7:0] ACCESS_CLOCKS = 8'h00;
  localparam logic [7:0] TRANSFER_RATE = 8'h32;
  localparam logic [11:0] CLASS_SET = 12'h135;
  localparam logic [3:0] BLOCK_EXP = 4'h9;
  localparam logic [2:0] CURRENT_CODE = 3'h6;
  localparam logic [6:0] ERASE_UNIT_CODE = 7'h1F;
  localparam logic [6:0] GROUP_CODE = 7'h00;
  localparam logic [2:0] WRITE_RATIO = 3'h5;
  localparam logic [11:0] CAPACITY_FIELD = 12'hE93;
  localparam logic [2:0] CAPACITY_EXP = 3'h5;
  localparam logic [15:0] RCA_RESET = 16'h0000;
  localparam int POS_ACCESS_CLOCKS = 104;
  localparam int POS_READ_EXP = 80;
  localparam int POS_CAPACITY = 62;
  localparam int POS_CAP_EXP = 47;
  localparam int POS_ERASE_ONE = 46;
  localparam int POS_BYTE_WRITE = 21;
  localparam int POS_LAYOUT_GROUP = 15;
  localparam int POS_COPY = 14;
  localparam int POS_PERM = 13;
  localparam int POS_TEMP = 12;
  localparam int POS_LAYOUT = 10;
  localparam int POS_CRC = 1;
  localparam int ACCESS_UNIT_CYCLES = 100;
  localparam logic [63:0] CFG_VALUE = {4'h0, 4'h0, 1'b1, 3'h2, 4'h5, 48'h0};
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_WDATA = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0C;
  localparam logic [7:0] APB_BLOCKS = 8'h10;
  localparam logic [7:0] APB_INFO = 8'h14;
  localparam logic [7:0] APB_ACCESS = 8'h18;

  // Seven-bit checksum, polynomial x^7 + x^3 + 1, first bit the highest.
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7
endpackage : sdc_pkg

//--- src/sdc_link_if.sv
// Register access link between the card register bank and its controller.
// Assumes one shared clock; the controller holds req until ack.
`timescale 1ns/1ps
interface sdc_link_if;
  logic req;
  logic wr;
  logic [1:0] sel;
  logic [1:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic err;

  modport card (input req, input wr, input sel, input idx, input wdata,
    output rdata, output ack, output err);
  modport host (output req, output wr, output sel, output idx, output wdata,
    input rdata, input ack, input err);
endinterface : sdc_link_if

//--- src/sdc_card_regs.sv
// Card end: identification and configuration register bank of the card.
// Assumes the controller on the link holds a request until ack is seen.
`timescale 1ns/1ps
module sdc_card_regs #(
  parameter logic [11:0] CAPACITY = sdc_pkg::CAPACITY_FIELD,
  parameter logic [2:0] CAP_EXP = sdc_pkg::CAPACITY_EXP
) (
  input wire logic pclk,
  input wire logic presetn,
  sdc_link_if.card link,
  output logic [15:0] card_address,
  output logic write_locked
);
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [15:0] relative_card_address;
    logic layout_group;
    logic copy;
    logic perm;
    logic temp;
    logic [1:0] layout;
    logic [6:0] crc;
    logic otp_used;
    logic locked;
  } sdc_card_state_t;

  // Builds the full card-specific data image from the live field values.
  function automatic logic [127:0] csd_image(input logic lg, input logic cp,
      input logic pm, input logic tp, input logic [1:0] lay, input logic [6:0] c);
    csd_image = {2'h0, 6'h00,
      sdc_pkg::ACCESS_TIME,
      sdc_pkg::ACCESS_CLOCKS,
      sdc_pkg::TRANSFER_RATE,
      sdc_pkg::CLASS_SET,
      sdc_pkg::BLOCK_EXP,
      1'b1,
      1'b0, 1'b0,
      1'b0,
      2'h0, CAPACITY,
      {4{sdc_pkg::CURRENT_CODE}},
      CAP_EXP,
      1'b1,
      sdc_pkg::ERASE_UNIT_CODE,
      sdc_pkg::GROUP_CODE,
      1'b0,
      2'h0,
      sdc_pkg::WRITE_RATIO,
      sdc_pkg::BLOCK_EXP,
      1'b0,
      5'h00, lg, cp, pm, tp, lay,
      2'h0, c, 1'b1};
  endfunction : csd_image

  localparam logic [127:0] CSD_SHIP = csd_image(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 7'h00);
  localparam logic [6:0] CRC_SHIP = sdc_pkg::crc7(CSD_SHIP[127:8]);

  sdc_card_state_t s_q;
  sdc_card_state_t s_d;
  logic [127:0] csd_now;
  logic [1:0] last_idx;
  logic in_range;
  logic [31:0] word_rd;

  always_comb begin
    csd_now = csd_image(s_q.layout_group, s_q.copy, s_q.perm, s_q.temp, s_q.layout,
      s_q.crc);
    unique case (link.sel)
      sdc_pkg::SEL_CSD: last_idx = sdc_pkg::CSD_WORDS_LAST;
      sdc_pkg::SEL_RCA: last_idx = sdc_pkg::RCA_WORDS_LAST;
      sdc_pkg::SEL_CFG: last_idx = sdc_pkg::CFG_WORDS_LAST;
      default: last_idx = 2'h0;
    endcase
    in_range = (link.sel != 2'h3) && (link.idx <= last_idx);
    unique case (link.sel)
      sdc_pkg::SEL_CSD: word_rd = csd_now[link.idx * 32 +: 32];
      sdc_pkg::SEL_RCA: word_rd = {16'h0000, s_q.relative_card_address};
      sdc_pkg::SEL_CFG: word_rd = sdc_pkg::CFG_VALUE[link.idx[0] * 32 +: 32];
      default: word_rd = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    if (link.req && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.err = !in_range;
      s_d.rdata = (in_range && !link.wr) ? word_rd : 32'h0000_0000;
      if (in_range && link.wr) begin
        if (link.sel == sdc_pkg::SEL_RCA) begin
          s_d.relative_card_address = link.wdata[15:0];
        end
        if (link.sel == sdc_pkg::SEL_CSD && link.idx == 2'h0) begin
          s_d.temp = link.wdata[sdc_pkg::POS_TEMP];
          s_d.crc = link.wdata[sdc_pkg::POS_CRC +: 7];
          if (!s_q.otp_used) begin
            s_d.otp_used = 1'b1;
            s_d.layout_group = link.wdata[sdc_pkg::POS_LAYOUT_GROUP];
            s_d.copy = link.wdata[sdc_pkg::POS_COPY];
            s_d.perm = link.wdata[sdc_pkg::POS_PERM];
            s_d.layout = link.wdata[sdc_pkg::POS_LAYOUT +: 2];
          end
        end
      end
    end
    s_d.locked = s_d.perm || s_d.temp;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{ack: 1'b0, err: 1'b0, rdata: 32'h0000_0000, relative_card_address: sdc_pkg::RCA_RESET,
        layout_group: 1'b0, copy: 1'b0, perm: 1'b0, temp: 1'b0, layout: 2'h0,
        crc: CRC_SHIP, otp_used: 1'b0, locked: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.ack = s_q.ack;
  assign link.err = s_q.err;
  assign link.rdata = s_q.rdata;
  assign card_address = s_q.relative_card_address;
  assign write_locked = s_q.locked;
endmodule : sdc_card_regs

//--- src/sdc_host_ctrl.sv
// Controller end: APB slave that reads and writes the card registers.
// Assumes an APB master on pclk and the card bank on the same clock.
`timescale 1ns/1ps
module sdc_host_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sdc_link_if.host link
);
  typedef enum logic [0:0] {H_IDLE = 1'b0, H_WAIT = 1'b1} sdc_host_fsm_t;
  typedef struct packed {
    sdc_host_fsm_t fsm;
    logic req;
    logic wr;
    logic [1:0] sel;
    logic [1:0] idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
    logic err;
    logic [127:0] shadow;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sdc_host_state_t;

  sdc_host_state_t s_q;
  sdc_host_state_t s_d;
  logic [11:0] cap_field;
  logic [2:0] cap_exp;
  logic [21:0] blocks;
  logic [15:0] access_cycles;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_acc;

  always_comb begin
    cap_field = s_q.shadow[sdc_pkg::POS_CAPACITY +: 12];
    cap_exp = s_q.shadow[sdc_pkg::POS_CAP_EXP +: 3];
    blocks = 22'((23'(cap_field) + 23'h1) << (4'(cap_exp) + 4'h2));
    access_cycles = 16'(s_q.shadow[sdc_pkg::POS_ACCESS_CLOCKS +: 8]
      * sdc_pkg::ACCESS_UNIT_CYCLES);
    rd_ok = 1'b1;
    unique case (paddr)
      sdc_pkg::APB_CMD: rd_mux = {22'h0, s_q.idx, 4'h0, s_q.sel, s_q.wr, 1'b0};
      sdc_pkg::APB_WDATA: rd_mux = s_q.wdata;
      sdc_pkg::APB_RDATA: rd_mux = s_q.rdata;
      sdc_pkg::APB_STATUS: rd_mux = {29'h0, s_q.err, s_q.done, s_q.fsm == H_WAIT};
      sdc_pkg::APB_BLOCKS: rd_mux = {10'h000, blocks};
      sdc_pkg::APB_INFO: rd_mux = {26'h0, s_q.shadow[sdc_pkg::POS_READ_EXP +: 4],
        s_q.shadow[sdc_pkg::POS_ERASE_ONE],
        s_q.shadow[sdc_pkg::POS_BYTE_WRITE]};
      sdc_pkg::APB_ACCESS: rd_mux = {16'h0000, access_cycles};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    wr_acc = psel && penable && s_q.pready && pwrite;
    s_d.pready = psel && !penable;
    if (psel && !penable) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_mux;
      s_d.pslverr = !rd_ok || (pwrite && paddr != sdc_pkg::APB_CMD
        && paddr != sdc_pkg::APB_WDATA);
    end
    if (wr_acc && paddr == sdc_pkg::APB_WDATA) begin
      s_d.wdata = pwdata;
    end
    unique case (s_q.fsm)
      H_IDLE: begin
        if (wr_acc && paddr == sdc_pkg::APB_CMD) begin
          s_d.wr = pwdata[1];
          s_d.sel = pwdata[3:2];
          s_d.idx = pwdata[9:8];
          if (pwdata[0]) begin
            s_d.fsm = H_WAIT;
            s_d.req = 1'b1;
            s_d.done = 1'b0;
            s_d.err = 1'b0;
            if (pwdata[1] && pwdata[3:2] == sdc_pkg::SEL_CSD && pwdata[9:8] == 2'h0) begin
              s_d.wdata[sdc_pkg::POS_CRC +: 7] = sdc_pkg::crc7(
                {s_q.shadow[127:16], s_q.wdata[15:8]});
            end
          end
        end
      end
      H_WAIT: begin
        if (link.ack) begin
          s_d.fsm = H_IDLE;
          s_d.req = 1'b0;
          s_d.done = 1'b1;
          s_d.err = link.err;
          if (!s_q.wr) begin
            s_d.rdata = link.rdata;
          end
          // The shadow follows read data only, since the card may ignore written bits.
          if (!link.err && !s_q.wr && s_q.sel == sdc_pkg::SEL_CSD) begin
            s_d.shadow[s_q.idx * 32 +: 32] = link.rdata;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{fsm: H_IDLE, req: 1'b0, wr: 1'b0, sel: 2'h0, idx: 2'h0,
        wdata: 32'h0000_0000, rdata: 32'h0000_0000, done: 1'b0, err: 1'b0,
        shadow: 128'h0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.req = s_q.req;
  assign link.wr = s_q.wr;
  assign link.sel = s_q.sel;
  assign link.idx = s_q.idx;
  assign link.wdata = s_q.wdata;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
endmodule : sdc_host_ctrl

//--- test/sdc_link_props.sv
// Checker of the link between the card register bank and its controller.
// Assumes the signals of sdc_link_if and the single clock pclk.
`timescale 1ns/1ps
module sdc_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [1:0] sel,
  input wire logic [1:0] idx,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ok;
  assign rd_ok = ack && !wr && !err;
  property p_answer; $rose(req) |=> ack ##1 !ack && !req; endproperty
  a_answer: assert property (p_answer) else $error("link answer timing wrong");
  property p_w3; rd_ok && sel == 2'h0 && idx == 2'h3 |-> rdata == 32'h002D0032; endproperty
  a_w3: assert property (p_w3) else $error("csd word3 wrong");
  property p_w2; rd_ok && sel == 2'h0 && idx == 2'h2 |-> rdata[31:12] == 20'h13598;
  endproperty
  a_w2: assert property (p_w2) else $error("csd word2 wrong");
  property p_cur; rd_ok && sel == 2'h0 && idx == 2'h1 |-> rdata[29:18] == 12'hDB6;
  endproperty
  a_cur: assert property (p_cur) else $error("current codes wrong");
  property p_ers; rd_ok && sel == 2'h0 && idx == 2'h1 |-> rdata[14:0] == 15'h4F80;
  endproperty
  a_ers: assert property (p_ers) else $error("erase fields wrong");
  property p_w0; rd_ok && sel == 2'h0 && idx == 2'h0 |-> rdata[31:16] == 16'h1640;
  endproperty
  a_w0: assert property (p_w0) else $error("csd word0 wrong");
  property p_cfg; rd_ok && sel == 2'h2 && idx == 2'h1 |-> rdata[23] && rdata[31:24] == 8'h0;
  endproperty
  a_cfg: assert property (p_cfg) else $error("erased polarity wrong");
  property p_bad; ack && sel == 2'h3 |-> err && rdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped select accepted");
  c_rd: cover property (rd_ok && sel == 2'h0);
  c_wr: cover property (ack && wr && sel == 2'h1);
  c_err: cover property (ack && err);
endmodule : sdc_link_props

//--- test/testbench.sv
// Self-checking bench: APB master on the controller, card bank on the link.
// Assumes both ends on pclk at 200 MHz with asynchronous active-low reset.
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, st;
  logic pready, pslverr, er, write_locked;
  logic [15:0] card_address, relative_card_address;
  logic [3:0] bad [3] = '{4'hC, 4'h5, 4'hA};
  int err_count = 0;
  int checked = 0;
  sdc_link_if link ();
  sdc_card_regs #(.CAPACITY(12'hE93), .CAP_EXP(3'h5)) sdc_card_regs_inst (.pclk(pclk),
    .presetn(presetn), .link(link), .card_address(card_address),
    .write_locked(write_locked));
  sdc_host_ctrl sdc_host_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  sdc_link_props sdc_link_props_inst (.pclk(pclk), .presetn(presetn), .req(link.req),
    .wr(link.wr), .sel(link.sel), .idx(link.idx), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack), .err(link.err));
  always #2.5 pclk = ~pclk;
  function automatic logic [31:0] blocks(input logic [11:0] c, input logic [2:0] e);
    return (32'(c) + 32'h1) << (32'(e) + 2);
  endfunction : blocks
  function automatic logic [6:0] crc_of(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc_of
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input logic w, input logic [1:0] s, input logic [1:0] i);
    apb(1'b1, sdc_pkg::APB_CMD, {22'h0, i, 4'h0, s, w, 1'b1});
    do begin
      apb(1'b0, sdc_pkg::APB_STATUS, 32'h0);
    end while (rd[1] !== 1'b1);
    st = rd;
    apb(1'b0, sdc_pkg::APB_RDATA, 32'h0);
  endtask : op
  task automatic print_verdict;
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(47454));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    op(1'b0, sdc_pkg::SEL_CSD, 2'h3);
    chk("csd word3", 32'h002D0032, rd);
    op(1'b0, sdc_pkg::SEL_CSD, 2'h2);
    chk("csd word2", 32'h135983A4, rd);
    op(1'b0, sdc_pkg::SEL_CSD, 2'h1);
    chk("csd word1", 32'hF6DACF80, rd);
    op(1'b0, sdc_pkg::SEL_CSD, 2'h0);
    chk("csd word0", 32'h16400001, rd & 32'hFFFFFF01);
    chk("ship crc", {25'h0, crc_of({96'h002D0032_135983A4_F6DACF80, 24'h164000})},
      {25'h0, rd[7:1]});
    op(1'b0, sdc_pkg::SEL_CFG, 2'h1);
    chk("cfg word1", 32'h00A50000, rd);
    op(1'b0, sdc_pkg::SEL_CFG, 2'h0);
    chk("cfg word0", 32'h0, rd);
    apb(1'b0, sdc_pkg::APB_INFO, 32'h0);
    chk("info", 32'h26, rd);
    apb(1'b0, sdc_pkg::APB_BLOCKS, 32'h0);
    chk("blocks", blocks(12'hE93, 3'h5), rd);
    apb(1'b0, sdc_pkg::APB_ACCESS, 32'h0);
    chk("access", 32'h0, rd);
    repeat (4) begin
      relative_card_address = 16'($urandom);
      apb(1'b1, sdc_pkg::APB_WDATA, {16'h0, relative_card_address});
      apb(1'b0, sdc_pkg::APB_WDATA, 32'h0);
      chk("wdata read", {16'h0, relative_card_address}, rd);
      op(1'b1, sdc_pkg::SEL_RCA, 2'h0);
      chk("address", {16'h0, relative_card_address}, {16'h0, card_address});
      op(1'b0, sdc_pkg::SEL_RCA, 2'h0);
      chk("rca read", {16'h0, relative_card_address}, {16'h0, rd[15:0]});
    end
    for (int k = 0; k < 3; k++) begin
      op(1'b0, bad[k][3:2], bad[k][1:0]);
      chk("link err", 32'h1, {31'h0, st[2]});
    end
    apb(1'b0, sdc_pkg::APB_CMD, 32'h0);
    chk("cmd read", 32'h00000208, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, sdc_pkg::APB_STATUS, 32'hF);
    chk("ro write", 32'h1, {31'h0, er});
    apb(1'b1, sdc_pkg::APB_WDATA, 32'h00007000);
    op(1'b1, sdc_pkg::SEL_CSD, 2'h0);
    chk("lock set", 32'h1, {31'h0, write_locked});
    op(1'b0, sdc_pkg::SEL_CSD, 2'h0);
    chk("locks read", 32'h16407001, rd & 32'hFFFFFF01);
    chk("new crc", {25'h0, crc_of({96'h002D0032_135983A4_F6DACF80, 24'h164070})},
      {25'h0, rd[7:1]});
    apb(1'b1, sdc_pkg::APB_WDATA, 32'h0);
    op(1'b1, sdc_pkg::SEL_CSD, 2'h0);
    op(1'b0, sdc_pkg::SEL_CSD, 2'h0);
    chk("once kept", 32'h16406001, rd & 32'hFFFFFF01);
    chk("perm lock", 32'h1, {31'h0, write_locked});
    print_verdict();
  end
endmodule : testbench
